// >>> verilog/dmi_pkg.sv
// Constants, field layouts and types shared by the DDR3L init/mode block.
package dmi_pkg;

    // ==========================================================
    // Register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_CONTROL  = 8'h04;
    localparam logic [7:0] REG_DLL_LOCK = 8'h08;
    localparam logic [7:0] REG_ZQ_INIT  = 8'h0c;
    localparam logic [7:0] REG_MR0      = 8'h10;
    localparam logic [7:0] REG_MR1      = 8'h14;
    localparam logic [7:0] REG_MR2      = 8'h18;
    localparam logic [7:0] REG_MR3      = 8'h1c;

    // Status and control bit positions.
    localparam int unsigned ST_STATE_LSB  = 0;
    localparam int unsigned ST_DLL_LOCKED = 2;
    localparam int unsigned ST_ZQ_DONE    = 3;
    localparam int unsigned ST_TERM_HIZ   = 4;
    localparam int unsigned ST_EARLY_READ = 5;
    localparam int unsigned ST_CKE_SEEN   = 6;
    localparam int unsigned CTRL_CLR_EARLY = 0;

    // ==========================================================
    // Mode register layout
    localparam int unsigned MR_W       = 16;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned MR0_BL_LSB = 0;
    localparam int unsigned MR0_BT     = 3;
    localparam int unsigned MR0_CL_A2  = 2;
    localparam int unsigned MR0_CL_LSB = 4;
    localparam int unsigned MR0_TM     = 7;
    localparam int unsigned MR0_DLLRST = 8;
    localparam int unsigned MR0_WR_LSB = 9;
    localparam int unsigned MR0_PPD    = 12;
    localparam int unsigned MR1_DLLDIS = 0;
    localparam int unsigned MR1_AL_LSB = 3;
    localparam int unsigned MR1_RTT_A  = 2;
    localparam int unsigned MR1_RTT_B  = 6;
    localparam int unsigned MR1_RTT_C  = 9;
    localparam int unsigned OTF_BIT    = 12;
    localparam int unsigned ZQ_LONG_BIT = 10;

    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [1:0] AL_CL1    = 2'h1;
    localparam logic [1:0] AL_CL2    = 2'h2;
    localparam logic [1:0] BA_MR0    = 2'h0;
    localparam logic [1:0] BA_MR1    = 2'h1;
    localparam logic [1:0] BA_MR2    = 2'h2;
    localparam logic [1:0] BA_MR3    = 2'h3;
    localparam logic [4:0] CL_BASE   = 5'h04;
    localparam logic [4:0] AL_ONE    = 5'h01;
    localparam logic [4:0] AL_TWO    = 5'h02;
    localparam logic [2:0] LAST_BEAT = 3'h7;

    // Lock and calibration waits, counted in command-clock edges.
    localparam logic [CNT_W-1:0] DLL_LOCK_DEF = 16'h0200;
    localparam logic [CNT_W-1:0] ZQ_INIT_DEF  = 16'h0200;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_WAIT_CKE,
        ST_CONFIG,
        ST_READY
    } dmi_init_e;

endpackage

// >>> verilog/dmi_burst_order.sv
// Column order of one beat inside a read or write burst.
`timescale 1ns/1ps
module dmi_burst_order
(
    input  wire logic [2:0] start_col,
    input  wire logic [2:0] beat,
    input  wire logic       interleave,
    input  wire logic       is_write,
    input  wire logic       chop,
    output logic      [2:0] col,
    output logic            hiz
);

    // ==========================================================
    // Order generation
    // Writes ignore the start column except bit 2 for a chopped burst.
    always_comb
    begin
        if (is_write)
        begin
            if (chop)
                col = {start_col[2], beat[1:0]};
            else
                col = beat;
        end
        else if (interleave)
            col = start_col ^ beat;
        else
            col = {start_col[2] ^ beat[2],
                   2'(start_col[1:0] + beat[1:0])};
        // The back half of a chopped burst drives nothing.
        hiz = chop && beat[2];
    end

endmodule

// >>> verilog/dmi_init_mode.sv
// Initialization sequencer and mode registers of the DDR3L device.
`timescale 1ns/1ps
module dmi_init_mode
#(
    parameter logic [15:0] DLL_LOCK_CK = dmi_pkg::DLL_LOCK_DEF,
    parameter logic [15:0] ZQ_INIT_CK  = dmi_pkg::ZQ_INIT_DEF
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        pin_reset_n,
    input  wire logic        pin_ck,
    input  wire logic        pin_cke,
    input  wire logic        pin_cs_n,
    input  wire logic        pin_ras_n,
    input  wire logic        pin_cas_n,
    input  wire logic        pin_we_n,
    input  wire logic [2:0]  pin_ba,
    input  wire logic [15:0] pin_addr,
    input  wire logic        pin_odt,
    output logic             term_on,
    output logic             term_hiz,
    output logic             dev_ready,
    output logic             dll_locked,
    output logic             early_read_err,
    output logic             burst_valid,
    output logic      [2:0]  burst_col,
    output logic             burst_dq_hiz,
    output logic      [4:0]  read_latency,
    output logic      [2:0]  wr_recovery_code,
    output logic             ppd_fast_exit
);

    localparam int unsigned PIN_W = 27;

    // ==========================================================
    // Pin synchronisers
    logic [PIN_W-1:0] meta_ff;
    logic [PIN_W-1:0] sync_ff;
    logic             ck_prev_ff;

    // Every pin crosses two flops; only the second stage is used.
    always_ff @(posedge clk_sys)
    begin
        meta_ff <= {pin_reset_n, pin_ck, pin_cke, pin_cs_n, pin_ras_n,
                    pin_cas_n, pin_we_n, pin_ba, pin_addr, pin_odt};
        sync_ff <= meta_ff;
    end

    logic        s_reset_n;
    logic        s_ck;
    logic        s_cke;
    logic [3:0]  s_cmd;
    logic [2:0]  s_ba;
    logic [15:0] s_addr;
    logic        s_odt;
    assign {s_reset_n, s_ck, s_cke, s_cmd, s_ba, s_addr, s_odt} = sync_ff;

    // Command clock edge finder; pins are taken on its rising edge.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ck_prev_ff <= 1'b0;
        else
            ck_prev_ff <= s_ck;
    end

    logic ck_rise;
    assign ck_rise = s_ck && !ck_prev_ff;

    // ==========================================================
    // Command decode, valid only with CKE high on a clock edge
    logic live;
    logic cmd_mrs;
    logic cmd_zqcl;
    logic cmd_rd;
    logic cmd_wr;
    assign live     = ck_rise && s_reset_n && s_cke;
    assign cmd_mrs  = live && (s_cmd == 4'h0) && !s_ba[2];
    assign cmd_zqcl = live && (s_cmd == 4'h6) && s_addr[dmi_pkg::ZQ_LONG_BIT];
    assign cmd_rd   = live && (s_cmd == 4'h5);
    assign cmd_wr   = live && (s_cmd == 4'h4);

    // ==========================================================
    // Register port state
    logic [15:0] dll_lock_ck_ff;
    logic [15:0] zq_init_ck_ff;
    logic        clr_early;
    assign clr_early = reg_wr && (reg_addr == dmi_pkg::REG_CONTROL)
                       && reg_wdata[dmi_pkg::CTRL_CLR_EARLY];

    // Software may shorten or stretch the lock and calibration waits.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dll_lock_ck_ff <= DLL_LOCK_CK;
            zq_init_ck_ff  <= ZQ_INIT_CK;
        end
        else if (reg_wr && (reg_addr == dmi_pkg::REG_DLL_LOCK))
            dll_lock_ck_ff <= reg_wdata[15:0];
        else if (reg_wr && (reg_addr == dmi_pkg::REG_ZQ_INIT))
            zq_init_ck_ff <= reg_wdata[15:0];
    end

    // ==========================================================
    // Mode registers
    logic [15:0] mr0_ff;
    logic [15:0] mr1_ff;
    logic [15:0] mr2_ff;
    logic [15:0] mr3_ff;
    logic        dll_rst_go;
    assign dll_rst_go = cmd_mrs && (s_ba[1:0] == dmi_pkg::BA_MR0)
                        && s_addr[dmi_pkg::MR0_DLLRST];

    // A write replaces the whole register; there is no array to disturb.
    // Nothing here reaches the array, so mode writes leave it intact.
    // Contents are cleared in reset since their value is undefined anyway.
    always_ff @(posedge clk_sys)
    begin
        if (rst || !s_reset_n)
        begin
            mr0_ff <= '0;
            mr1_ff <= '0;
            mr2_ff <= '0;
            mr3_ff <= '0;
        end
        else if (cmd_mrs)
        begin
            if (s_ba[1:0] == dmi_pkg::BA_MR0)
                mr0_ff <= s_addr;
            else if (s_ba[1:0] == dmi_pkg::BA_MR1)
                mr1_ff <= s_addr;
            else if (s_ba[1:0] == dmi_pkg::BA_MR2)
                mr2_ff <= s_addr;
            else
                mr3_ff <= s_addr;
        end
        else if (ck_rise)
            mr0_ff[dmi_pkg::MR0_DLLRST] <= 1'b0;
    end

    // ==========================================================
    // DLL lock and calibration timers, in command-clock edges
    logic [15:0] dll_cnt_ff;
    logic        dll_locked_ff;
    logic [15:0] zq_cnt_ff;
    logic        zq_busy_ff;
    logic        zq_done_ff;

    always_ff @(posedge clk_sys)
    begin
        if (rst || !s_reset_n)
        begin
            dll_cnt_ff    <= '0;
            dll_locked_ff <= 1'b0;
        end
        else if (dll_rst_go)
        begin
            dll_cnt_ff    <= '0;
            dll_locked_ff <= 1'b0;
        end
        else if (ck_rise && !dll_locked_ff)
        begin
            dll_cnt_ff <= dll_cnt_ff + 16'h0001;
            if (dll_cnt_ff + 16'h0001 >= dll_lock_ck_ff)
                dll_locked_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || !s_reset_n)
        begin
            zq_cnt_ff  <= '0;
            zq_busy_ff <= 1'b0;
            zq_done_ff <= 1'b0;
        end
        else if (cmd_zqcl)
        begin
            zq_cnt_ff  <= '0;
            zq_busy_ff <= 1'b1;
            zq_done_ff <= 1'b0;
        end
        else if (ck_rise && zq_busy_ff)
        begin
            zq_cnt_ff <= zq_cnt_ff + 16'h0001;
            if (zq_cnt_ff + 16'h0001 >= zq_init_ck_ff)
            begin
                zq_busy_ff <= 1'b0;
                zq_done_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Initialization sequence
    dmi_pkg::dmi_init_e state_ff;

    // The pin reset restarts the whole flow, including a warm reset.
    always_ff @(posedge clk_sys)
    begin
        if (rst || !s_reset_n)
            state_ff <= dmi_pkg::ST_RESET;
        else
        begin
            case (state_ff)
                dmi_pkg::ST_RESET:
                    state_ff <= dmi_pkg::ST_WAIT_CKE;
                dmi_pkg::ST_WAIT_CKE:
                    if (ck_rise && s_cke)
                        state_ff <= dmi_pkg::ST_CONFIG;
                dmi_pkg::ST_CONFIG:
                    if (dll_locked_ff && zq_done_ff)
                        state_ff <= dmi_pkg::ST_READY;
                default:
                    state_ff <= state_ff;
            endcase
        end
    end

    // Termination is held off until CKE first registers high.
    logic rtt_nom_on;
    assign rtt_nom_on = mr1_ff[dmi_pkg::MR1_RTT_A]
                        || mr1_ff[dmi_pkg::MR1_RTT_B]
                        || mr1_ff[dmi_pkg::MR1_RTT_C];

    always_ff @(posedge clk_sys)
    begin
        if (rst || !s_reset_n)
        begin
            term_hiz <= 1'b1;
            term_on  <= 1'b0;
        end
        else if (state_ff == dmi_pkg::ST_RESET
                 || state_ff == dmi_pkg::ST_WAIT_CKE)
        begin
            term_hiz <= !(ck_rise && s_cke);
            term_on  <= 1'b0;
        end
        else
        begin
            term_hiz <= !(s_odt && rtt_nom_on);
            term_on  <= s_odt && rtt_nom_on;
        end
    end

    // ==========================================================
    // Early-read violation; a new event beats a clear in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            early_read_err <= 1'b0;
        else if (cmd_rd && !dll_locked_ff)
            early_read_err <= 1'b1;
        else if (clr_early)
            early_read_err <= 1'b0;
    end

    // ==========================================================
    // Burst sequencing, one beat per command-clock edge
    logic [2:0] start_col_ff;
    logic [2:0] beat_ff;
    logic       bursting_ff;
    logic       is_write_ff;
    logic       chop_ff;
    logic [2:0] order_col;
    logic       order_hiz;
    logic       new_chop;

    // Mode field picks the length; A12 decides only in per-command mode.
    always_comb
    begin
        if (mr0_ff[1:0] == dmi_pkg::BL_FIXED4)
            new_chop = 1'b1;
        else if (mr0_ff[1:0] == dmi_pkg::BL_OTF)
            new_chop = !s_addr[dmi_pkg::OTF_BIT];
        else
            new_chop = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || !s_reset_n)
        begin
            start_col_ff <= '0;
            beat_ff      <= '0;
            bursting_ff  <= 1'b0;
            is_write_ff  <= 1'b0;
            chop_ff      <= 1'b0;
        end
        else if (cmd_rd || cmd_wr)
        begin
            start_col_ff <= s_addr[2:0];
            beat_ff      <= '0;
            bursting_ff  <= 1'b1;
            is_write_ff  <= cmd_wr;
            chop_ff      <= new_chop;
        end
        else if (ck_rise && bursting_ff)
        begin
            beat_ff     <= beat_ff + 3'h1;
            bursting_ff <= (beat_ff != dmi_pkg::LAST_BEAT);
        end
    end

    dmi_burst_order u_order
    (
        .start_col  (start_col_ff),
        .beat       (beat_ff),
        .interleave (mr0_ff[dmi_pkg::MR0_BT]),
        .is_write   (is_write_ff),
        .chop       (chop_ff),
        .col        (order_col),
        .hiz        (order_hiz)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            burst_valid  <= 1'b0;
            burst_col    <= '0;
            burst_dq_hiz <= 1'b1;
        end
        else
        begin
            burst_valid  <= bursting_ff && !order_hiz;
            burst_col    <= order_col;
            burst_dq_hiz <= !bursting_ff || order_hiz;
        end
    end

    // ==========================================================
    // Decoded mode fields and register read port
    logic [4:0] cas_lat;
    logic [4:0] add_lat;
    assign cas_lat = dmi_pkg::CL_BASE
                     + {2'h0, mr0_ff[6:4]};
    always_comb
    begin
        if (mr1_ff[4:3] == dmi_pkg::AL_CL1)
            add_lat = cas_lat - dmi_pkg::AL_ONE;
        else if (mr1_ff[4:3] == dmi_pkg::AL_CL2)
            add_lat = cas_lat - dmi_pkg::AL_TWO;
        else
            add_lat = '0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            read_latency     <= '0;
            wr_recovery_code <= '0;
            ppd_fast_exit    <= 1'b0;
            dev_ready        <= 1'b0;
            dll_locked       <= 1'b0;
        end
        else
        begin
            read_latency     <= 5'(add_lat + cas_lat);
            wr_recovery_code <= mr0_ff[11:9];
            ppd_fast_exit    <= mr0_ff[dmi_pkg::MR0_PPD];
            dev_ready        <= (state_ff == dmi_pkg::ST_READY);
            dll_locked       <= dll_locked_ff;
        end
    end

    // Unmapped addresses read as zero; reads have no side effects.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (!reg_rd)
            reg_rdata <= '0;
        else if (reg_addr == dmi_pkg::REG_STATUS)
        begin
            reg_rdata <= '0;
            reg_rdata[dmi_pkg::ST_STATE_LSB +: 2] <= state_ff;
            reg_rdata[dmi_pkg::ST_DLL_LOCKED] <= dll_locked_ff;
            reg_rdata[dmi_pkg::ST_ZQ_DONE]    <= zq_done_ff;
            reg_rdata[dmi_pkg::ST_TERM_HIZ]   <= term_hiz;
            reg_rdata[dmi_pkg::ST_EARLY_READ] <= early_read_err;
            reg_rdata[dmi_pkg::ST_CKE_SEEN]   <=
                (state_ff == dmi_pkg::ST_CONFIG)
                || (state_ff == dmi_pkg::ST_READY);
        end
        else if (reg_addr == dmi_pkg::REG_DLL_LOCK)
            reg_rdata <= {16'h0000, dll_lock_ck_ff};
        else if (reg_addr == dmi_pkg::REG_ZQ_INIT)
            reg_rdata <= {16'h0000, zq_init_ck_ff};
        else if (reg_addr == dmi_pkg::REG_MR0)
            reg_rdata <= {16'h0000, mr0_ff};
        else if (reg_addr == dmi_pkg::REG_MR1)
            reg_rdata <= {16'h0000, mr1_ff};
        else if (reg_addr == dmi_pkg::REG_MR2)
            reg_rdata <= {16'h0000, mr2_ff};
        else if (reg_addr == dmi_pkg::REG_MR3)
            reg_rdata <= {16'h0000, mr3_ff};
        else
            reg_rdata <= '0;
    end

endmodule

// >>> sim/dmi_init_mode_sva.sv
// Port-level assertions for the DDR3L init and mode block.
`timescale 1ns/1ps
module dmi_init_mode_sva
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        pin_reset_n,
    input wire logic        pin_cke,
    input wire logic        term_on,
    input wire logic        term_hiz,
    input wire logic        dev_ready,
    input wire logic        dll_locked,
    input wire logic        early_read_err,
    input wire logic        burst_valid,
    input wire logic        burst_dq_hiz
);
    // ==========================================================
    // Termination, readiness and bursts
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Reset is the cause here, so this property must not be disabled by it.
    property p_rst;
        disable iff (1'b0) rst |=> term_hiz && !term_on && !dev_ready;
    endproperty
    a_rst: assert property (p_rst) else $error("reset outputs wrong");
    property p_pin_rst; (!pin_reset_n)[*4] |=> term_hiz; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("no hiz");
    property p_on_hiz; term_on |-> !term_hiz; endproperty
    a_on_hiz: assert property (p_on_hiz) else $error("on in hiz");
    property p_hiz_cke; $fell(term_hiz) |-> pin_cke; endproperty
    a_hiz_cke: assert property (p_hiz_cke) else $error("hiz left");
    property p_ready; $rose(dev_ready) |-> dll_locked; endproperty
    a_ready: assert property (p_ready) else $error("ready unlocked");
    property p_beat; burst_valid |-> !burst_dq_hiz; endproperty
    a_beat: assert property (p_beat) else $error("beat in hiz");
    property p_beat_len; $rose(burst_valid) |=> burst_valid[*7]; endproperty
    a_beat_len: assert property (p_beat_len) else $error("short");
    property p_early; $rose(early_read_err) |-> !$past(dll_locked); endproperty
    a_early: assert property (p_early) else $error("false early");
    property p_early_clr;
        reg_wr && reg_addr == dmi_pkg::REG_CONTROL && reg_wdata[0]
            && dll_locked |=> !early_read_err;
    endproperty
    a_early_clr: assert property (p_early_clr) else $error("kept");
endmodule
bind dmi_init_mode dmi_init_mode_sva u_sva (.*);

// >>> sim/dmi_ctl_model.sv
// Behavioural memory controller driving the device pins.
`timescale 1ns/1ps
module dmi_ctl_model
#(
    parameter int GAP = 5
)
(
    input  wire logic        clk_sys,
    output logic             pin_reset_n,
    output logic             pin_ck,
    output logic             pin_cke,
    output logic             pin_cs_n,
    output logic             pin_ras_n,
    output logic             pin_cas_n,
    output logic             pin_we_n,
    output logic      [2:0]  pin_ba,
    output logic      [15:0] pin_addr,
    output logic             pin_odt
);
    // ==========================================================
    // Command clock and idle pins
    // The clock is offset from clk_sys so that its edges never tie.
    initial
    begin
        {pin_reset_n, pin_ck, pin_cke, pin_odt} = 4'h0;
        {pin_cs_n, pin_ras_n, pin_cas_n, pin_we_n} = 4'hf;
        pin_ba = 3'h0;
        pin_addr = 16'h0000;
        #3;
        forever #80 pin_ck = ~pin_ck;
    end
    // Level pins move just after a clk_sys edge.
    task automatic pins(input logic r, input logic c, input logic o);
        @(posedge clk_sys);
        pin_reset_n <= r;
        pin_cke <= c;
        pin_odt <= o;
    endtask
    // A command covers one ck rise; idle periods go first for spacing.
    task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                       input logic [15:0] a);
        repeat (GAP) @(negedge pin_ck);
        @(posedge clk_sys);
        {pin_cs_n, pin_ras_n, pin_cas_n, pin_we_n} <= c;
        pin_ba <= b;
        pin_addr <= a;
        @(negedge pin_ck);
        @(posedge clk_sys);
        pin_cs_n <= 1'b1;
        pin_ba <= ~b;
        pin_addr <= ~a;
    endtask
endmodule

// >>> sim/dmi_init_mode_tb.sv
// Self-checking bench for the DDR3L init and mode block.
`timescale 1ns/1ps
module dmi_init_mode_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        pin_reset_n, pin_ck, pin_cke, pin_cs_n, pin_ras_n;
    logic        pin_cas_n, pin_we_n, pin_odt, term_on, term_hiz;
    logic        dev_ready, dll_locked, early_read_err, burst_valid;
    logic        burst_dq_hiz, ppd_fast_exit;
    logic [2:0]  pin_ba, burst_col, wr_recovery_code;
    logic [15:0] pin_addr;
    logic [4:0]  read_latency;
    int          n_fail = 0;
    int          checks_done = 0;
    // ==========================================================
    // Design, partner and clock
    dmi_init_mode #(.DLL_LOCK_CK(16'h0010), .ZQ_INIT_CK(16'h0010)) DUT (.*);
    dmi_ctl_model u_ctl (.*);
    always #10 clk_sys = ~clk_sys;
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), reg_rdata, e);
    endtask
    task automatic mrs(input logic [1:0] b, input logic [15:0] a);
        u_ctl.cmd(4'h0, {1'b0, b}, a);
    endtask
    // Expected beats are nibbles, first beat on top; 8 marks a tristate beat.
    task automatic burst(input logic [3:0] c, input logic [15:0] a,
                         input logic [31:0] e);
        logic [3:0] b;
        u_ctl.cmd(c, 3'h0, a);
        @(negedge clk_sys);
        for (int n = 0; n < 40 && burst_valid !== 1'b1; n++)
            @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            b = e[31-4*i -: 4];
            if (b[3])
                chk("tail", {burst_valid, burst_dq_hiz}, 2'b01);
            else
                chk("beat", {burst_valid, burst_dq_hiz, burst_col},
                    {2'b10, b[2:0]});
            repeat (8) @(negedge clk_sys);
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        wr(dmi_pkg::REG_DLL_LOCK, 32'hffff0010);
        wr(dmi_pkg::REG_ZQ_INIT, 32'h0010);
        rd(dmi_pkg::REG_DLL_LOCK, 32'h0010);
        rd(dmi_pkg::REG_ZQ_INIT, 32'h0010);
        rd(8'h40, 32'h0);
        rd(dmi_pkg::REG_STATUS, 32'h10);
    endtask
    task automatic t_init;
        u_ctl.pins(1'b1, 1'b0, 1'b0);
        repeat (20) @(posedge clk_sys);
        chk("hiz_no_cke", term_hiz, 1'b1);
        u_ctl.pins(1'b1, 1'b1, 1'b0);
        repeat (20) @(posedge clk_sys);
        // With ODT low the termination stays off once CKE has been seen.
        chk("hiz_cke", term_hiz, 1'b1);
        rd(dmi_pkg::REG_STATUS, 32'h52);
        mrs(2'h2, 16'h0018);
        mrs(2'h3, 16'h0003);
        mrs(2'h1, 16'h0044);
        mrs(2'h0, 16'h1b20);
        u_ctl.cmd(4'h5, 3'h0, 16'h0000);
        repeat (12) @(posedge clk_sys);
        chk("early_read", early_read_err, 1'b1);
        u_ctl.cmd(4'h6, 3'h0, 16'h0400);
        for (int n = 0; n < 4000 && dev_ready !== 1'b1; n++)
            @(negedge clk_sys);
        chk("ready", {dev_ready, dll_locked}, 2'b11);
        rd(dmi_pkg::REG_MR0, 32'h1a20);
        rd(dmi_pkg::REG_MR1, 32'h0044);
        rd(dmi_pkg::REG_MR2, 32'h0018);
        rd(dmi_pkg::REG_MR3, 32'h0003);
        chk("fields", {read_latency, wr_recovery_code, ppd_fast_exit},
            9'h06b);
        rd(dmi_pkg::REG_STATUS, 32'h7f);
        wr(dmi_pkg::REG_CONTROL, 32'h1);
        rd(dmi_pkg::REG_STATUS, 32'h5f);
    endtask
    task automatic t_rewrite;
        mrs(2'h1, 16'h0002);
        rd(dmi_pkg::REG_MR1, 32'h0002);
        u_ctl.pins(1'b1, 1'b1, 1'b1);
        repeat (20) @(posedge clk_sys);
        chk("term_off", term_on, 1'b0);
        u_ctl.pins(1'b1, 1'b1, 1'b0);
        mrs(2'h1, 16'h0044);
        repeat (12) @(negedge pin_ck);
        u_ctl.pins(1'b1, 1'b1, 1'b1);
        repeat (20) @(posedge clk_sys);
        chk("term_on", term_on, 1'b1);
        u_ctl.pins(1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_bursts;
        burst(4'h5, 16'h0003, 32'h30127456);
        mrs(2'h0, 16'h1a29);
        burst(4'h5, 16'h1003, 32'h32107654);
        burst(4'h5, 16'h0005, 32'h54768888);
        burst(4'h4, 16'h0005, 32'h45678888);
        burst(4'h4, 16'h1003, 32'h01234567);
        mrs(2'h0, 16'h1a22);
        burst(4'h5, 16'h1006, 32'h67458888);
    endtask
    task automatic t_warm;
        u_ctl.pins(1'b0, 1'b0, 1'b0);
        repeat (10) @(posedge clk_sys);
        chk("warm", {term_hiz, dev_ready}, 2'b10);
        t_init;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs;
        t_init;
        t_rewrite;
        t_bursts;
        t_warm;
        end_sim;
    end
    initial
    begin
        #400000;
        n_fail++;
        end_sim;
    end
endmodule
